//--- design/timer_ctrl_pkg.sv
// constants, field layouts and carrier types for the timer control register bank
package timer_ctrl_pkg;
  // register byte offsets
  localparam logic [11:0] CNT_START_OFS   = 12'h04c;
  localparam logic [11:0] FLAG_MIRROR_OFS = 12'h050;
  localparam logic [11:0] MODE_CTRL_OFS   = 12'h054;
  localparam logic [11:0] SYNC_CFG_OFS    = 12'h058;
  localparam logic [11:0] PRESET_VAL_OFS  = 12'h05c;
  localparam logic [11:0] MASK_BUF_OFS    = 12'h060;
  localparam logic [11:0] PROTECT_OFS     = 12'h084;
  localparam logic [11:0] SCHEME_OFS      = 12'h088;
  // field positions in the mode register
  localparam int MODE_FIE_BIT   = 7;
  localparam int MODE_FM_LSB    = 5;
  localparam int MODE_CT_BIT    = 4;
  localparam int MODE_TR_BIT    = 3;
  localparam int MODE_WRITE_PROTECT_DISABLE_BIT = 2;
  localparam int MODE_INIT_BIT  = 1;
  localparam int MODE_EFE_BIT   = 0;
  // field positions in the sync register
  localparam int SYNC_SW_BIT    = 7;
  localparam int SYNC_TRIG_LSB  = 4;
  localparam int SYNC_MSEL_BIT  = 3;
  localparam int SYNC_COUNTER_RELOAD_ON_SYNC_BIT = 2;
  localparam int SYNC_MAX_BIT   = 1;
  localparam int SYNC_MIN_BIT   = 0;
  // own control registers
  localparam int PROT_WRITE_PROTECT_ENABLE_BIT  = 0;
  localparam int SCHEME_SEL_BIT = 0;
  // reset values
  localparam logic [7:0]  MODE_RST      = 8'h04;
  localparam logic [7:0]  SYNC_RST      = 8'h00;
  localparam logic [15:0] CNT_START_RST = 16'h0000;
  // fault-mode encodings and channel groups
  localparam logic [1:0]  FM_OFF        = 2'h0;
  localparam logic [1:0]  FM_EVEN_MAN   = 2'h1;
  localparam logic [1:0]  FM_ALL_MAN    = 2'h2;
  localparam logic [1:0]  FM_ALL_AUTO   = 2'h3;
  localparam logic [7:0]  EVEN_CHANNELS = 8'h55;
  localparam logic [7:0]  ALL_CHANNELS  = 8'hff;

  // synchronisation commands sent to the counter and channel datapaths
  typedef struct packed {
    logic load_values;    // copy modulo, start value and channel values
    logic load_mask;      // copy output mask buffer
    logic reload_counter; // counter takes its start value
  } sync_cmd_s;

  // global mode fields seen by the datapaths
  typedef struct packed {
    logic [7:0] fault_channels;
    logic       fault_auto_clear;
    logic       capture_test_enable;
    logic       enhanced_feature_enable;
    logic       write_protect_disable;
  } mode_view_s;
endpackage

//--- design/timer_mode_sync_status_regs.sv
// global control, status, mode and synchronisation registers of an eight-channel timer
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps

module timer_mode_sync_status_regs
(
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output      logic [31:0]                prdata,
  output      logic                       pready,
  output      logic                       pslverr,
  // events from the timer core
  input  wire logic [7:0]                 channel_event,
  input  wire logic                       fault_detected,
  input  wire logic [2:0]                 hw_trigger,
  input  wire logic                       counter_at_max,
  input  wire logic                       counter_at_min,
  // controls towards the timer core
  output      logic [7:0]                 channel_event_flag,
  output      logic [15:0]                counter_start_reg,
  output      timer_ctrl_pkg::mode_view_s mode_view,
  output      logic                       fault_irq,
  output      logic                       trigger_restrict_select,
  output      logic                       sync_scheme_select,
  output      timer_ctrl_pkg::sync_cmd_s  sync_cmd,
  output      logic                       output_preset_strobe,
  output      logic [7:0]                 output_preset_values,
  output      logic [7:0]                 output_mask_register
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [31:0] rdata_next;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  // storage
  logic [15:0] cnt_start_buf_reg;
  logic [15:0] cnt_start_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  clr_armed_reg;
  logic        fie_reg;
  logic [1:0]  fm_reg;
  logic        ct_reg;
  logic        tr_reg;
  logic        write_protect_disable_reg;
  logic        wp_armed_reg;
  logic        efe_reg;
  logic        sw_pend_reg;
  logic [2:0]  trig_en_reg;
  logic        msel_reg;
  logic        counter_reload_on_sync_reg;
  logic        lp_max_reg;
  logic        lp_min_reg;
  logic [7:0]  preset_val_reg;
  logic        preset_strobe_reg;
  logic [7:0]  mask_buf_reg;
  logic [7:0]  mask_act_reg;
  logic        scheme_reg;
  logic        fault_irq_reg;
  logic        value_pend_reg;
  logic [2:0]  hw_prev_reg;
  timer_ctrl_pkg::sync_cmd_s  sync_cmd_reg;
  timer_ctrl_pkg::mode_view_s mode_view_reg;

  // an access completes on the first access-phase edge
  assign acc    = psel & penable & pready_reg;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;

  // read mux and address hit; reserved bits are zero-filled here
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    hit        = 1'b1;
    unique case (paddr)
      timer_ctrl_pkg::CNT_START_OFS:   rdata_next[15:0] = cnt_start_buf_reg;
      timer_ctrl_pkg::FLAG_MIRROR_OFS: rdata_next[7:0]  = flags_reg;
      timer_ctrl_pkg::MODE_CTRL_OFS:
        rdata_next[7:0] = {fie_reg, fm_reg, ct_reg, tr_reg, write_protect_disable_reg, 1'b0, efe_reg};
      timer_ctrl_pkg::SYNC_CFG_OFS:
        rdata_next[7:0] = {sw_pend_reg, trig_en_reg, msel_reg, counter_reload_on_sync_reg, lp_max_reg, lp_min_reg};
      timer_ctrl_pkg::PRESET_VAL_OFS:  rdata_next[7:0]  = preset_val_reg;
      timer_ctrl_pkg::MASK_BUF_OFS:    rdata_next[7:0]  = mask_buf_reg;
      timer_ctrl_pkg::PROTECT_OFS:     rdata_next[0]    = ~write_protect_disable_reg;
      timer_ctrl_pkg::SCHEME_OFS:      rdata_next[0]    = scheme_reg;
      default:                         hit              = 1'b0;
    endcase
  end

  // zero-wait slave: ready and data are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= psel & ~penable;
      prdata_reg  <= (psel & ~penable & ~pwrite) ? rdata_next : 32'h0000_0000;
      pslverr_reg <= psel & ~penable & ~hit;
    end
  end

  a_apb_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready && penable ##1 !pready))
    else $error("apb access did not finish in one access cycle");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr != timer_ctrl_pkg::CNT_START_OFS) |-> prdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");

  ////////////////////////////////////////////////////////////////////////////////
  // counter start value: buffered, made active by a value load or in legacy mode

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_start_buf_reg <= timer_ctrl_pkg::CNT_START_RST;
      cnt_start_reg     <= timer_ctrl_pkg::CNT_START_RST;
    end
    else
    begin
      if (wr_acc && paddr == timer_ctrl_pkg::CNT_START_OFS)
        cnt_start_buf_reg <= pwdata[15:0];
      if (sync_cmd_reg.load_values || !efe_reg)
        cnt_start_reg <= cnt_start_buf_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel event flags with read-then-write-zero clearing

  logic       stat_wr;
  logic [7:0] flag_clear;

  assign stat_wr    = wr_acc && paddr == timer_ctrl_pkg::FLAG_MIRROR_OFS;
  // only bits armed by a read, written 0, with no new event, may clear
  assign flag_clear = stat_wr ? (clr_armed_reg & ~pwdata[7:0] & ~channel_event) : 8'h00;

  // a new event disarms the bit, so a stale clearing write has no effect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_reg     <= 8'h00;
      clr_armed_reg <= 8'h00;
    end
    else
    begin
      flags_reg <= (flags_reg & ~flag_clear) | channel_event;
      if (stat_wr)
        clr_armed_reg <= 8'h00;
      else if (rd_acc && paddr == timer_ctrl_pkg::FLAG_MIRROR_OFS)
        clr_armed_reg <= (clr_armed_reg | prdata_reg[7:0]) & ~channel_event;
      else
        clr_armed_reg <= clr_armed_reg & ~channel_event;
    end
  end

  a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (channel_event != 8'h00) |=> ((channel_event_flag & $past(channel_event)) == $past(channel_event)))
    else $error("channel event did not set its flag");

  a_flag_one_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    stat_wr |=> ((flags_reg & $past(pwdata[7:0] & flags_reg)) == $past(pwdata[7:0] & flags_reg)))
    else $error("writing one changed a set flag");

  a_flag_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (($past(flags_reg) & ~flags_reg & ~$past(clr_armed_reg)) == 8'h00))
    else $error("flag cleared without a prior read");

  ////////////////////////////////////////////////////////////////////////////////
  // mode register, write protection and fault control

  logic mode_wr;
  logic prot_wr;
  logic fault_on;

  assign mode_wr  = wr_acc && paddr == timer_ctrl_pkg::MODE_CTRL_OFS;
  assign prot_wr  = wr_acc && paddr == timer_ctrl_pkg::PROTECT_OFS;
  assign fault_on = fm_reg != timer_ctrl_pkg::FM_OFF;

  // protected fields only move while protection is disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fie_reg <= timer_ctrl_pkg::MODE_RST[timer_ctrl_pkg::MODE_FIE_BIT];
      fm_reg  <= timer_ctrl_pkg::MODE_RST[timer_ctrl_pkg::MODE_FM_LSB +: 2];
      ct_reg  <= timer_ctrl_pkg::MODE_RST[timer_ctrl_pkg::MODE_CT_BIT];
      tr_reg  <= timer_ctrl_pkg::MODE_RST[timer_ctrl_pkg::MODE_TR_BIT];
      efe_reg <= timer_ctrl_pkg::MODE_RST[timer_ctrl_pkg::MODE_EFE_BIT];
    end
    else if (mode_wr)
    begin
      fie_reg <= pwdata[timer_ctrl_pkg::MODE_FIE_BIT];
      tr_reg  <= pwdata[timer_ctrl_pkg::MODE_TR_BIT];
      if (write_protect_disable_reg)
      begin
        fm_reg  <= pwdata[timer_ctrl_pkg::MODE_FM_LSB +: 2];
        ct_reg  <= pwdata[timer_ctrl_pkg::MODE_CT_BIT];
        efe_reg <= pwdata[timer_ctrl_pkg::MODE_EFE_BIT];
      end
    end
  end

  // disable sets only after the enable bit was read as 1; enable write clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_protect_disable_reg    <= timer_ctrl_pkg::MODE_RST[timer_ctrl_pkg::MODE_WRITE_PROTECT_DISABLE_BIT];
      wp_armed_reg <= 1'b0;
    end
    else
    begin
      if (prot_wr && pwdata[timer_ctrl_pkg::PROT_WRITE_PROTECT_ENABLE_BIT])
      begin
        write_protect_disable_reg    <= 1'b0;
        wp_armed_reg <= 1'b0;
      end
      else if (mode_wr && pwdata[timer_ctrl_pkg::MODE_WRITE_PROTECT_DISABLE_BIT] && wp_armed_reg)
      begin
        write_protect_disable_reg    <= 1'b1;
        wp_armed_reg <= 1'b0;
      end
      else if (rd_acc && paddr == timer_ctrl_pkg::PROTECT_OFS && prdata_reg[0])
        wp_armed_reg <= 1'b1;
    end
  end

  // fault channel groups, interrupt request and the exported mode view
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_irq_reg <= 1'b0;
      mode_view_reg <= '0;
    end
    else
    begin
      fault_irq_reg <= fault_detected & fault_on & fie_reg;
      unique case (fm_reg)
        timer_ctrl_pkg::FM_OFF:      mode_view_reg.fault_channels <= 8'h00;
        timer_ctrl_pkg::FM_EVEN_MAN: mode_view_reg.fault_channels <= timer_ctrl_pkg::EVEN_CHANNELS;
        timer_ctrl_pkg::FM_ALL_MAN:  mode_view_reg.fault_channels <= timer_ctrl_pkg::ALL_CHANNELS;
        timer_ctrl_pkg::FM_ALL_AUTO: mode_view_reg.fault_channels <= timer_ctrl_pkg::ALL_CHANNELS;
      endcase
      mode_view_reg.fault_auto_clear        <= fm_reg == timer_ctrl_pkg::FM_ALL_AUTO;
      mode_view_reg.capture_test_enable     <= ct_reg;
      mode_view_reg.enhanced_feature_enable <= efe_reg;
      mode_view_reg.write_protect_disable   <= write_protect_disable_reg;
    end
  end

  a_fault_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_detected && fie_reg && fm_reg != 2'h0) |=> fault_irq)
    else $error("fault interrupt missing");

  a_protect_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_wr && !write_protect_disable_reg) |=> ($stable(fm_reg) && $stable(ct_reg) && $stable(efe_reg)))
    else $error("protected field written while protected");

  a_protect_unlock: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(write_protect_disable_reg) |-> $past(wp_armed_reg && mode_wr && pwdata[2]))
    else $error("protection disabled without read of enable");

  ////////////////////////////////////////////////////////////////////////////////
  // output preset strobe and preset values

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      preset_val_reg    <= 8'h00;
      preset_strobe_reg <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == timer_ctrl_pkg::PRESET_VAL_OFS)
        preset_val_reg <= pwdata[7:0];
      preset_strobe_reg <= mode_wr & pwdata[timer_ctrl_pkg::MODE_INIT_BIT];
    end
  end

  sequence seq_single_pulse;
    output_preset_strobe ##1 !output_preset_strobe;
  endsequence

  a_preset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_wr && pwdata[1]) |=> seq_single_pulse)
    else $error("preset strobe not a single pulse");

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisation config, triggers and loading points

  logic       sync_wr;
  logic       sw_fire;
  logic       hw_fire;
  logic       restrict_on;
  logic       value_trig;
  logic       mask_trig;
  logic       lp_enabled;
  logic       at_lp;
  logic       load_values_now;

  assign sync_wr     = wr_acc && paddr == timer_ctrl_pkg::SYNC_CFG_OFS;
  assign sw_fire     = sync_wr && pwdata[timer_ctrl_pkg::SYNC_SW_BIT];
  assign hw_fire     = |(hw_trigger & ~hw_prev_reg & trig_en_reg);
  assign restrict_on = ~scheme_reg & tr_reg;
  // restricted: software drives value loads, hardware drives mask and counter
  assign value_trig  = sw_fire | (hw_fire & ~restrict_on);
  assign mask_trig   = hw_fire | (sw_fire & ~restrict_on);
  assign lp_enabled  = lp_max_reg | lp_min_reg;
  assign at_lp       = (lp_max_reg & counter_at_max) | (lp_min_reg & counter_at_min);
  // with loading points on, a pending value load waits for the next one;
  // if the points are switched off meanwhile, the pending load goes out at once
  assign load_values_now = lp_enabled ? ((value_pend_reg | value_trig) & at_lp)
                                      : (value_pend_reg | value_trig);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_en_reg <= timer_ctrl_pkg::SYNC_RST[timer_ctrl_pkg::SYNC_TRIG_LSB +: 3];
      msel_reg    <= timer_ctrl_pkg::SYNC_RST[timer_ctrl_pkg::SYNC_MSEL_BIT];
      counter_reload_on_sync_reg  <= timer_ctrl_pkg::SYNC_RST[timer_ctrl_pkg::SYNC_COUNTER_RELOAD_ON_SYNC_BIT];
      lp_max_reg  <= timer_ctrl_pkg::SYNC_RST[timer_ctrl_pkg::SYNC_MAX_BIT];
      lp_min_reg  <= timer_ctrl_pkg::SYNC_RST[timer_ctrl_pkg::SYNC_MIN_BIT];
      scheme_reg  <= 1'b0;
    end
    else
    begin
      if (sync_wr)
      begin
        trig_en_reg <= pwdata[timer_ctrl_pkg::SYNC_TRIG_LSB +: 3];
        msel_reg    <= pwdata[timer_ctrl_pkg::SYNC_MSEL_BIT];
        counter_reload_on_sync_reg  <= pwdata[timer_ctrl_pkg::SYNC_COUNTER_RELOAD_ON_SYNC_BIT];
        lp_max_reg  <= pwdata[timer_ctrl_pkg::SYNC_MAX_BIT];
        lp_min_reg  <= pwdata[timer_ctrl_pkg::SYNC_MIN_BIT];
      end
      if (wr_acc && paddr == timer_ctrl_pkg::SCHEME_OFS)
        scheme_reg <= pwdata[timer_ctrl_pkg::SCHEME_SEL_BIT];
    end
  end

  // software trigger reads 1 until its value load has happened
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_pend_reg    <= 1'b0;
      value_pend_reg <= 1'b0;
      hw_prev_reg    <= 3'h0;
    end
    else
    begin
      hw_prev_reg    <= hw_trigger;
      sw_pend_reg    <= (sw_pend_reg | sw_fire) & ~load_values_now;
      value_pend_reg <= (value_pend_reg | (value_trig & lp_enabled)) & ~load_values_now;
    end
  end

  // sync commands and the active output mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_cmd_reg <= '0;
      mask_act_reg <= 8'h00;
    end
    else
    begin
      sync_cmd_reg.load_values    <= load_values_now;
      sync_cmd_reg.load_mask      <= mask_trig;
      sync_cmd_reg.reload_counter <= mask_trig & counter_reload_on_sync_reg;
      if (!msel_reg || mask_trig)
        mask_act_reg <= mask_buf_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_buf_reg <= 8'h00;
    else if (wr_acc && paddr == timer_ctrl_pkg::MASK_BUF_OFS)
      mask_buf_reg <= pwdata[7:0];
  end

  sequence seq_hw_edge;
    (hw_trigger[0] && trig_en_reg[0]) ##1 (!hw_trigger[0] && trig_en_reg[0]) ##1
      (hw_trigger[0] && trig_en_reg[0] && !restrict_on);
  endsequence

  a_hw_trig_edge: assert property (@(posedge pclk) disable iff (!presetn)
    seq_hw_edge |=> sync_cmd.load_mask)
    else $error("hardware trigger edge did not sync");

  a_restrict_sw: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_fire && restrict_on && !hw_fire) |=> !sync_cmd.load_mask)
    else $error("restricted software trigger loaded mask");

  a_mask_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !msel_reg |=> (output_mask_register == $past(mask_buf_reg)))
    else $error("mask did not follow its buffer");

  a_loadpoint_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (lp_enabled && !at_lp) |=> !sync_cmd.load_values)
    else $error("value load outside a loading point");

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign channel_event_flag      = flags_reg;
  assign counter_start_reg       = cnt_start_reg;
  assign mode_view               = mode_view_reg;
  assign fault_irq               = fault_irq_reg;
  assign trigger_restrict_select = tr_reg;
  assign sync_scheme_select      = scheme_reg;
  assign sync_cmd                = sync_cmd_reg;
  assign output_preset_strobe    = preset_strobe_reg;
  assign output_preset_values    = preset_val_reg;
  assign output_mask_register    = mask_act_reg;

endmodule

//--- test/tb_timer_mode_sync_status_regs.sv
// self-checking bench for the timer control, status, mode and sync registers
`timescale 1ns/1ps
module tb_timer_mode_sync_status_regs;
  logic                       pclk = 1'b0;
  logic                       presetn = 1'b0;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [11:0]                paddr = 12'h000;
  logic [31:0]                pwdata = 32'h0;
  logic [7:0]                 channel_event = 8'h00;
  logic                       fault_detected = 1'b1;
  logic [2:0]                 hw_trigger = 3'h0;
  logic                       counter_at_max = 1'b0;
  logic                       counter_at_min = 1'b0;
  logic [15:0]                st;
  logic [31:0]                prdata, r;
  logic                       pready, pslverr, err, fault_irq, trigger_restrict_select;
  logic                       sync_scheme_select, output_preset_strobe;
  logic [7:0]                 channel_event_flag, output_preset_values, output_mask_register, m;
  logic [15:0]                counter_start_reg;
  timer_ctrl_pkg::mode_view_s mode_view;
  timer_ctrl_pkg::sync_cmd_s  sync_cmd;
  int                         n_fail = 0;
  int                         n_tests = 0;
  int                         h, lv, lm, rc;
  ////////////////////////////////////////////////////////////////////////////////
  // trigger and counter inputs stand in for the timer core, which is outside
  timer_mode_sync_status_regs timer_mode_sync_status_regs_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_event,
    .fault_detected, .hw_trigger, .counter_at_max, .counter_at_min,
    .channel_event_flag, .counter_start_reg, .mode_view, .fault_irq, .trigger_restrict_select,
    .sync_scheme_select, .sync_cmd, .output_preset_strobe, .output_preset_values,
    .output_mask_register);
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge pclk);
    channel_event <= v;
    @(posedge pclk);
    channel_event <= 8'h00;
  endtask
  // eight cycles with trigger and loading-point pulses at cycles 0 and 2; counts sync pulses
  task automatic run(input logic [2:0] t, input logic [1:0] p);
    lv = 0; lm = 0; rc = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      lv += sync_cmd.load_values;
      lm += sync_cmd.load_mask;
      rc += sync_cmd.reload_counter;
      hw_trigger <= (i == 0 || i == 2) ? t : 3'h0;
      {counter_at_max, counter_at_min} <= (i == 0 || i == 2) ? p : 2'b00;
    end
  endtask
  function automatic logic [7:0] chans(input logic [1:0] fm);
    return (fm == 2'h0) ? 8'h00 : (fm == 2'h1) ? timer_ctrl_pkg::EVEN_CHANNELS : 8'hff;
  endfunction
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs a few hundred cycles at most
  initial
  begin
    #200000;
    n_fail++;
    summarize;
  end
  initial
  begin
    void'($urandom(32'haf35));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, timer_ctrl_pkg::MODE_CTRL_OFS, 0); chk("mode_rst", r, 32'h4);
    apb(1, 12'h0f0, '1); chk("unmapped", 32'(err), 1);
    m = 8'($urandom);
    apb(1, timer_ctrl_pkg::CNT_START_OFS, {16'hffff, m, ~m});
    apb(0, timer_ctrl_pkg::CNT_START_OFS, 0); chk("start", r, {16'h0, m, ~m});
    st = {m, ~m};
    chk("start_act", counter_start_reg, st);
    apb(1, timer_ctrl_pkg::PRESET_VAL_OFS, 32'(m));
    apb(0, timer_ctrl_pkg::PRESET_VAL_OFS, 0); chk("oinit", r, 32'(m));
    chk("oinit_out", output_preset_values, m);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, {24'hffffff, 1'b0, m[6:0]});
    apb(0, timer_ctrl_pkg::SYNC_CFG_OFS, 0); chk("sync", r, {25'h0, m[6:0]});
    // flags: set, refuse a write of ones, then lose a clear to a fresh event
    repeat (4)
    begin
      m = 8'($urandom); h = $urandom_range(7, 0);
      ev(m);
      apb(0, timer_ctrl_pkg::FLAG_MIRROR_OFS, 0); chk("flags", r, 32'(m));
      apb(1, timer_ctrl_pkg::FLAG_MIRROR_OFS, 32'hff);
      apb(0, timer_ctrl_pkg::FLAG_MIRROR_OFS, 0); chk("flags_w1", r, 32'(m));
      ev(8'h01 << h);
      apb(1, timer_ctrl_pkg::FLAG_MIRROR_OFS, 0);
      @(posedge pclk);
      chk("flag_race", 32'(channel_event_flag), 32'h1 << h);
      apb(0, timer_ctrl_pkg::FLAG_MIRROR_OFS, 0);
      apb(1, timer_ctrl_pkg::FLAG_MIRROR_OFS, 0);
      apb(0, timer_ctrl_pkg::FLAG_MIRROR_OFS, 0); chk("flags_clr", r, 0);
    end
    // every fault mode with the fault interrupt enabled and a fault present
    for (int fm = 0; fm < 4; fm++)
    begin
      apb(1, timer_ctrl_pkg::MODE_CTRL_OFS, 32'h84 | (fm << 5));
      repeat (2) @(posedge pclk);
      chk("fchan", 32'(mode_view.fault_channels), 32'(chans(2'(fm))));
      chk("fauto", 32'(mode_view.fault_auto_clear), 32'(fm == 3));
      chk("firq", 32'(fault_irq), 32'(fm != 0));
    end
    fault_detected <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("firq_off", fault_irq, 0);
    apb(1, timer_ctrl_pkg::PROTECT_OFS, 1);
    apb(1, timer_ctrl_pkg::MODE_CTRL_OFS, 32'h15);
    apb(0, timer_ctrl_pkg::MODE_CTRL_OFS, 0); chk("locked", r, 32'h60);
    chk("wp_view", mode_view.write_protect_disable, 0);
    apb(0, timer_ctrl_pkg::PROTECT_OFS, 0);
    apb(1, timer_ctrl_pkg::MODE_CTRL_OFS, 32'h64);
    apb(1, timer_ctrl_pkg::MODE_CTRL_OFS, 32'h11);
    apb(0, timer_ctrl_pkg::MODE_CTRL_OFS, 0); chk("unlock", r, 32'h15);
    chk("capture_test_enable", 32'(mode_view.capture_test_enable), 1);
    chk("efe_view", mode_view.enhanced_feature_enable, 1);
    chk("write_protect_disable_view", mode_view.write_protect_disable, 1);
    apb(1, timer_ctrl_pkg::MODE_CTRL_OFS, 32'h17);
    h = 0;
    repeat (4) @(posedge pclk) h += output_preset_strobe;
    chk("preset", h, 1);
    apb(0, timer_ctrl_pkg::MODE_CTRL_OFS, 0); chk("init_rd", r, 32'h15);
    // enhanced mode: the active start value waits for a value load
    apb(1, timer_ctrl_pkg::CNT_START_OFS, 32'(~st));
    apb(0, timer_ctrl_pkg::CNT_START_OFS, 0); chk("start_hold", counter_start_reg, st);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h80);
    run(3'h0, 2'b00);
    chk("software_sync_trigger", lv, 1);
    chk("start_load", counter_start_reg, {16'h0, ~st});
    // mask follows its buffer every clock, then only on hardware trigger 0 with reload
    m = 8'($urandom);
    apb(1, timer_ctrl_pkg::MASK_BUF_OFS, 32'(m));
    run(3'h0, 2'b00); chk("mask_free", output_mask_register, m);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h1c);
    apb(1, timer_ctrl_pkg::MASK_BUF_OFS, 32'(~m));
    run(3'h2, 2'b00); chk("hw_off", lm, 0);
    chk("mask_hold", output_mask_register, m);
    run(3'h1, 2'b00); chk("hw_mask", lm, 2); chk("hw_vals", lv, 2);
    chk("counter_reload_on_sync", rc, 2);
    chk("mask_sync", output_mask_register, 8'(~m));
    // trigger restriction in scheme 0, then lifted by scheme 1
    apb(1, timer_ctrl_pkg::MODE_CTRL_OFS, 32'h1d);
    run(3'h1, 2'b00); chk("r_hw_vals", lv, 0); chk("r_hw_mask", lm, 2);
    chk("restrict", trigger_restrict_select, 1);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h08); // hardware enables off first
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h88);
    run(3'h0, 2'b00); chk("r_sw_vals", lv, 1); chk("r_sw_mask", lm, 0);
    apb(1, timer_ctrl_pkg::SCHEME_OFS, 1);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h88);
    run(3'h0, 2'b00); chk("s1_mask", lm, 1);
    chk("scheme", sync_scheme_select, 1);
    // loading points hold a software load; no hardware trigger is enabled
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h02);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h82);
    apb(0, timer_ctrl_pkg::SYNC_CFG_OFS, 0); chk("lp_pend", r, 32'h82);
    run(3'h0, 2'b10); chk("lp_max", lv, 1);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h01);
    apb(1, timer_ctrl_pkg::SYNC_CFG_OFS, 32'h81);
    run(3'h0, 2'b10); chk("lp_min_wait", lv, 0);
    run(3'h0, 2'b01); chk("lp_min", lv, 1);
    summarize;
  end
endmodule
